// [src/hsp_sched_regs.sv]
// Descriptor-area pending, asynchronous-done time-out and programmed-I/O read pointer registers.
// Assumes a same-clock processor port, a same-clock host engine and header data valid beside o_hdr_index.
// Behaviour
// - a pending area is walked; only valid, unskipped headers are executed.
// - pending bit 2 set walks the isochronous area; clear skips it.
// - pending bit 1 set walks the interrupt-transfer area; clear skips it.
// - pending bit 0 set walks the asynchronous area; clear skips it.
// - 32-bit millisecond time-out, reset zero, raises the interrupt when enabled.
// - the time-out is armed by asynchronous completions only.
// - a written start address is latched per bank and steps on every programmed-I/O read, except one in the same cycle as a write to that bank.
// - bits 17 to 16 select one of four banks with separate pointers.
// - bank selection steers programmed-I/O accesses only, never DMA.
// - bits 15 to 0 give the start of incrementing programmed-I/O reads.
//
// Implementation choice: the address-and-strobe port.
`include "hsp_params.svh"

module hsp_sched_regs #(
	parameter int          NDESC     = `HSP_NDESC,
	parameter int unsigned MS_CYCLES = `HSP_MS_CYCLES
) (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_reset,
	input  wire logic [`HSP_AW-1:0]         i_addr,
	input  wire logic [31:0]                i_wdata,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	output logic      [31:0]                o_rdata,
	input  wire logic                       i_hdr_valid,
	input  wire logic                       i_hdr_skip,
	output logic      [3:0]                 o_walk_state,
	output logic      [$clog2(NDESC)-1:0]   o_hdr_index,
	output logic                            o_exec,
	output logic      [2:0]                 o_exec_area,
	output logic      [$clog2(NDESC)-1:0]   o_exec_index,
	input  wire logic                       i_async_done,
	output logic                            o_async_done_irq,
	input  wire logic                       i_pio_rd,
	output logic                            o_pio_go,
	output logic      [15:0]                o_pio_addr,
	output logic      [1:0]                 o_pio_bank
);
	localparam int IW = $clog2(NDESC);
	localparam int BW = `HSP_BANK_HI - `HSP_BANK_LO + 1;
	localparam int AW = `HSP_ADDR_HI - `HSP_ADDR_LO + 1;

	typedef struct packed {
		logic [2:0]        pend;
		logic [31:0]       tmo;
		logic              ien;
		logic              irq;
		logic              armed;
		logic [31:0]       ms;
		logic [31:0]       rdata;
		hsp_pkg::hsp_walk_t walk;
		logic [IW-1:0]     idx;
		logic              exec;
		logic [2:0]        exec_area;
		logic [IW-1:0]     exec_idx;
		logic [BW-1:0]     bank;
		logic [AW-1:0]     pio_addr;
		logic              pio_go;
	} hsp_top_state_t;

	hsp_top_state_t st;
	hsp_top_state_t next_st;

	logic          restart;
	logic          ms_tick;
	logic [AW-1:0] cur_ptr;
	logic          wr_pend;
	logic          wr_tmo;
	logic          wr_ptr;
	logic          wr_ctl;
	logic          hdr_take;

	hsp_ptr_if #(.NBANK(1 << BW), .AW(AW)) ptr_if ();

	// Map a walk state onto the matching pending bit.
	function automatic logic [2:0] area_mask(input hsp_pkg::hsp_walk_t w);
		logic [2:0] m;
		m = 3'h0;
		case (w)
			hsp_pkg::walk_iso: m[`HSP_PEND_ISO] = 1'b1;
			hsp_pkg::walk_int: m[`HSP_PEND_INT] = 1'b1;
			hsp_pkg::walk_atl: m[`HSP_PEND_ATL] = 1'b1;
			default:           m = 3'h0;
		endcase
		return m;
	endfunction

	// Next pending area after the current one; periodic areas go first in each pass.
	function automatic hsp_pkg::hsp_walk_t area_after(input logic [2:0] pend, input hsp_pkg::hsp_walk_t cur);
		hsp_pkg::hsp_walk_t res;
		res = hsp_pkg::walk_idle;
		case (cur)
			hsp_pkg::walk_idle: begin
				if (pend[`HSP_PEND_ISO]) begin
					res = hsp_pkg::walk_iso;
				end else if (pend[`HSP_PEND_INT]) begin
					res = hsp_pkg::walk_int;
				end else if (pend[`HSP_PEND_ATL]) begin
					res = hsp_pkg::walk_atl;
				end
			end
			hsp_pkg::walk_iso: begin
				if (pend[`HSP_PEND_INT]) begin
					res = hsp_pkg::walk_int;
				end else if (pend[`HSP_PEND_ATL]) begin
					res = hsp_pkg::walk_atl;
				end
			end
			hsp_pkg::walk_int: begin
				if (pend[`HSP_PEND_ATL]) begin
					res = hsp_pkg::walk_atl;
				end
			end
			default: res = hsp_pkg::walk_idle;
		endcase
		return res;
	endfunction

	// Write decode; strobes come from same-clock logic, so no synchroniser is needed.
	assign wr_pend = i_wr && (i_addr == `HSP_OFF_PEND);
	assign wr_tmo  = i_wr && (i_addr == `HSP_OFF_TMO);
	assign wr_ptr  = i_wr && (i_addr == `HSP_OFF_PTR);
	assign wr_ctl  = i_wr && (i_addr == `HSP_OFF_CTL);

	// A header is acted on only inside a still-pending area and only when valid and not skipped.
	assign hdr_take = (st.walk != hsp_pkg::walk_idle) && (|(st.pend & area_mask(st.walk)))
		&& i_hdr_valid && !i_hdr_skip;

	// Pointer bank control; the selected bank steers programmed-I/O accesses, DMA never sees it.
	assign cur_ptr          = ptr_if.ptrs[st.bank];
	assign ptr_if.load      = wr_ptr;
	assign ptr_if.load_bank = i_wdata[`HSP_BANK_HI:`HSP_BANK_LO];
	assign ptr_if.load_addr = i_wdata[`HSP_ADDR_HI:`HSP_ADDR_LO];
	assign ptr_if.step      = i_pio_rd;
	assign ptr_if.step_bank = st.bank;

	hsp_bank_ptr #(
		.NBANK (1 << BW),
		.AW    (AW)
	) u_bank_ptr (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.ptr_if    (ptr_if.bank)
	);

	hsp_ms_tick #(
		.PERIOD (MS_CYCLES)
	) u_ms_tick (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_restart (restart),
		.o_tick    (ms_tick)
	);

	// Whole next state: register writes, read data, scheduler walk, time-out and pointer reads.
	always_comb begin
		next_st        = st;
		restart        = 1'b0;
		next_st.rdata  = `HSP_RST_WORD;
		next_st.exec   = 1'b0;
		next_st.pio_go = 1'b0;

		// Read data stand for one cycle only; unmapped addresses read zero.
		if (i_rd) begin
			case (i_addr)
				`HSP_OFF_PEND: next_st.rdata[`HSP_PEND_ISO:`HSP_PEND_ATL] = st.pend;
				`HSP_OFF_TMO:  next_st.rdata = st.tmo;
				`HSP_OFF_PTR: begin
					next_st.rdata[`HSP_BANK_HI:`HSP_BANK_LO] = st.bank;
					next_st.rdata[`HSP_ADDR_HI:`HSP_ADDR_LO] = cur_ptr;
				end
				`HSP_OFF_CTL: begin
					next_st.rdata[`HSP_CTL_IEN] = st.ien;
					next_st.rdata[`HSP_CTL_IRQ] = st.irq;
				end
				default: next_st.rdata = `HSP_RST_WORD;
			endcase
		end

		// Only the defined bits are stored, so reserved bits always read back as zero.
		if (wr_pend) begin
			next_st.pend = i_wdata[`HSP_PEND_ISO:`HSP_PEND_ATL];
		end
		if (wr_ptr) begin
			next_st.bank = i_wdata[`HSP_BANK_HI:`HSP_BANK_LO];
		end

		// Scheduler walk over the headers of each pending area in turn.
		case (st.walk)
			hsp_pkg::walk_idle: begin
				next_st.walk = area_after(st.pend, st.walk);
				next_st.idx  = '0;
			end
			hsp_pkg::walk_iso, hsp_pkg::walk_int, hsp_pkg::walk_atl: begin
				// A cleared pending bit abandons the area at once rather than finishing it.
				if (!(|(st.pend & area_mask(st.walk))) || st.idx == IW'(NDESC - 1)) begin
					next_st.walk = area_after(st.pend, st.walk);
					next_st.idx  = '0;
				end else begin
					next_st.idx = IW'(st.idx + 1'b1);
				end
			end
			default: begin
				next_st.walk = hsp_pkg::walk_idle;
				next_st.idx  = '0;
			end
		endcase
		if (hdr_take) begin
			next_st.exec      = 1'b1;
			next_st.exec_area = area_mask(st.walk);
			next_st.exec_idx  = st.idx;
		end

		// Asynchronous completions arm the time-out; later ones before expiry are coalesced.
		if (i_async_done && !st.armed) begin
			next_st.armed = 1'b1;
			next_st.ms    = '0;
			restart       = 1'b1;
		end else if (st.armed) begin
			if (st.ms >= st.tmo) begin
				next_st.armed = 1'b0;
			end else if (ms_tick) begin
				next_st.ms = st.ms + 32'h0000_0001;
			end
		end

		// A new time-out value restarts the millisecond count from zero.
		if (wr_tmo) begin
			next_st.tmo = i_wdata;
			next_st.ms  = '0;
			restart     = 1'b1;
		end

		// Interrupt clear by writing one; an expiry in the same cycle wins over the clear.
		if (wr_ctl) begin
			next_st.ien = i_wdata[`HSP_CTL_IEN];
			if (i_wdata[`HSP_CTL_IRQ]) begin
				next_st.irq = 1'b0;
			end
		end
		if (st.armed && !(i_async_done && !st.armed) && st.ms >= st.tmo && st.ien) begin
			next_st.irq = 1'b1;
		end

		// Programmed-I/O read takes the current pointer of the selected bank, which then steps.
		if (i_pio_rd) begin
			next_st.pio_go   = 1'b1;
			next_st.pio_addr = cur_ptr;
		end
	end

	// State register; every output below is a bit of it.
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			st      <= '0;
			st.walk <= hsp_pkg::walk_idle;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata          = st.rdata;
	assign o_walk_state     = st.walk;
	assign o_hdr_index      = st.idx;
	assign o_exec           = st.exec;
	assign o_exec_area      = st.exec_area;
	assign o_exec_index     = st.exec_idx;
	assign o_async_done_irq = st.irq;
	assign o_pio_go         = st.pio_go;
	assign o_pio_addr       = st.pio_addr;
	assign o_pio_bank       = st.bank;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);

	AST_EXEC_VALID: assert property (hdr_take |=> o_exec && o_exec_index == $past(st.idx))
		else $error("Valid header was not executed.");
	AST_EXEC_CAUSE: assert property (o_exec |-> $past(i_hdr_valid) && !$past(i_hdr_skip))
		else $error("Executed a header that was invalid or skipped.");
	AST_ISO_GATE: assert property (st.walk == hsp_pkg::walk_iso |-> $past(st.pend[`HSP_PEND_ISO]))
		else $error("Isochronous area walked while not pending.");
	AST_INT_GATE: assert property (st.walk == hsp_pkg::walk_int |-> $past(st.pend[`HSP_PEND_INT]))
		else $error("Interrupt-transfer area walked while not pending.");
	AST_ATL_GATE: assert property (st.walk == hsp_pkg::walk_atl |-> $past(st.pend[`HSP_PEND_ATL]))
		else $error("Asynchronous area walked while not pending.");
	AST_TMO_EXPIRE: assert property (st.armed && st.ms >= st.tmo && st.ien && !wr_ctl |=> o_async_done_irq)
		else $error("Time-out expired without raising the interrupt.");
	AST_IRQ_CAUSE: assert property ($rose(o_async_done_irq) |-> $past(st.armed))
		else $error("Interrupt raised without an asynchronous completion.");
	AST_ARM_CAUSE: assert property ($rose(st.armed) |-> $past(i_async_done))
		else $error("Time-out armed by something other than an asynchronous completion.");
	AST_PTR_LOAD: assert property (wr_ptr |=> cur_ptr == $past(i_wdata[`HSP_ADDR_HI:`HSP_ADDR_LO])
		&& o_pio_bank == $past(i_wdata[`HSP_BANK_HI:`HSP_BANK_LO]))
		else $error("Start address or bank not latched.");
	AST_PTR_STEP: assert property (i_pio_rd && !wr_ptr |=> o_pio_go && o_pio_addr == $past(cur_ptr)
		&& cur_ptr == AW'($past(cur_ptr) + 1'b1))
		else $error("Read pointer did not hand out and step.");
	AST_MS_RESTART: assert property (wr_tmo |=> st.ms == 32'h0000_0000 ##1 !ms_tick)
		else $error("Time-out write did not restart the millisecond count.");

	COV_EXEC: cover property (st.walk == hsp_pkg::walk_atl ##1 o_exec);
	COV_IRQ: cover property ($rose(o_async_done_irq));
	COV_PIO_TWO: cover property (i_pio_rd ##1 i_pio_rd);
endmodule

// [src/hsp_params.svh]
// Register map, field positions, reset values and timing of the schedule register block.
// Assumes it is included by bare name from every file that needs one of these constants.
`ifndef HSP_PARAMS_SVH
`define HSP_PARAMS_SVH

// Byte addresses of the registers on the processor port.
`define HSP_AW        12
`define HSP_OFF_PEND  12'h0334
`define HSP_OFF_TMO   12'h0338
`define HSP_OFF_PTR   12'h033C
`define HSP_OFF_CTL   12'h0350

// Descriptor-area pending bits.
`define HSP_PEND_ATL  0
`define HSP_PEND_INT  1
`define HSP_PEND_ISO  2

// Read pointer fields.
`define HSP_BANK_HI   17
`define HSP_BANK_LO   16
`define HSP_ADDR_HI   15
`define HSP_ADDR_LO   0

// Time-out control bits.
`define HSP_CTL_IEN   0
`define HSP_CTL_IRQ   1

// Reset value of every register word.
`define HSP_RST_WORD  32'h0000_0000

// One millisecond tick, as a time and as a count of system clocks.
`define HSP_MS_US     1000
`define HSP_CLK_MHZ   100
`define HSP_MS_CYCLES (`HSP_MS_US * `HSP_CLK_MHZ)

// Number of descriptor headers in each area.
`define HSP_NDESC     32

`endif

// [src/hsp_pkg.sv]
// Types shared by the schedule register block and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package hsp_pkg;

	// Walk state of the descriptor scheduler, one-hot.
	typedef enum logic [3:0] {
		walk_idle = 4'h1,
		walk_iso  = 4'h2,
		walk_int  = 4'h4,
		walk_atl  = 4'h8
	} hsp_walk_t;

endpackage

// [src/hsp_ptr_if.sv]
// Connection between the register block and its per-bank read pointers.
// Assumes both ends run on the same system clock.
interface hsp_ptr_if #(
	parameter int NBANK = 4,
	parameter int AW    = 16
);
	logic                       load;
	logic [$clog2(NBANK)-1:0]   load_bank;
	logic [AW-1:0]              load_addr;
	logic                       step;
	logic [$clog2(NBANK)-1:0]   step_bank;
	logic [NBANK-1:0][AW-1:0]   ptrs;

	modport ctrl (output load, output load_bank, output load_addr, output step, output step_bank, input ptrs);
	modport bank (input load, input load_bank, input load_addr, input step, input step_bank, output ptrs);
endinterface

// [src/hsp_bank_ptr.sv]
// Independent read pointers, one per memory bank.
// Assumes load and step come from logic on the same clock.
module hsp_bank_ptr #(
	parameter int NBANK = 4,
	parameter int AW    = 16
) (
	input  wire logic   i_sys_clk,
	input  wire logic   i_reset,
	hsp_ptr_if.bank     ptr_if
);
	typedef struct packed {
		logic [NBANK-1:0][AW-1:0] ptr;
	} hsp_bank_state_t;

	hsp_bank_state_t st;
	hsp_bank_state_t next_st;

	// A new start address wins over a step of the same bank, so software always restarts cleanly.
	always_comb begin
		next_st = st;
		if (ptr_if.step) begin
			next_st.ptr[ptr_if.step_bank] = AW'(st.ptr[ptr_if.step_bank] + 1'b1);
		end
		if (ptr_if.load) begin
			next_st.ptr[ptr_if.load_bank] = ptr_if.load_addr;
		end
	end

	// State register.
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ptr_if.ptrs = st.ptr;
endmodule

// [src/hsp_ms_tick.sv]
// Millisecond tick generator with a restart input.
// Assumes PERIOD is above one so ticks are never adjacent.
module hsp_ms_tick #(
	parameter int unsigned PERIOD = 100000
) (
	input  wire logic   i_sys_clk,
	input  wire logic   i_reset,
	input  wire logic   i_restart,
	output logic        o_tick
);
	localparam int CW = $clog2(PERIOD);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} hsp_tick_state_t;

	hsp_tick_state_t st;
	hsp_tick_state_t next_st;

	// A restart aligns the first tick a full period after the event that caused it.
	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		if (i_restart) begin
			next_st.cnt = '0;
		end else if (st.cnt == CW'(PERIOD - 1)) begin
			next_st.cnt  = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = CW'(st.cnt + 1'b1);
		end
	end

	// State register.
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_tick = st.tick;

	AST_TICK_GAP: assert property (@(posedge i_sys_clk) disable iff (i_reset) o_tick |=> !o_tick)
		else $error("Millisecond tick repeated in the next cycle.");
endmodule

// [sim/hsp_engine_model.sv]
// Host engine stand-in: answers header lookups and reports asynchronous completions.
// Assumes the scheduler shows one header index per cycle on the same clock.
module hsp_engine_model #(
	parameter int NDESC = 4
) (
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_reset,
	input  wire logic [3:0]               i_walk_state,
	input  wire logic [$clog2(NDESC)-1:0] i_hdr_index,
	input  wire logic                     i_exec,
	input  wire logic [2:0]               i_exec_area,
	output logic                          o_hdr_valid,
	output logic                          o_hdr_skip,
	output logic                          o_async_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic toggle;

	// Header 1 is live, header 2 is valid but skipped, the rest are empty.
	// While idle the lines wander, so the scheduler cannot lean on stale values.
	always_comb begin
		if (i_walk_state == 4'h1) begin
			o_hdr_valid = toggle;
			o_hdr_skip  = ~toggle;
		end else begin
			o_hdr_valid = (i_hdr_index == 1) || (i_hdr_index == 2);
			o_hdr_skip  = (i_hdr_index == 2);
		end
	end

	// An executed asynchronous header completes one cycle later.
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			toggle       <= 1'b0;
			o_async_done <= 1'b0;
		end else begin
			toggle       <= ~toggle;
			o_async_done <= i_exec && i_exec_area[0];
		end
	end
endmodule

// [sim/hsp_sched_regs_tb.sv]
// Self-checking bench for the schedule register block.
// Assumes the engine model answers headers and a 12-bit processor port.
`include "hsp_params.svh"

module hsp_sched_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NDESC = 4;
	localparam int IW    = $clog2(NDESC);
	logic          i_sys_clk, i_reset, i_wr, i_rd, i_pio_rd;
	logic [11:0]   i_addr;
	logic [31:0]   i_wdata, o_rdata;
	logic          hdr_valid, hdr_skip, async_done, o_exec, o_irq, o_pio_go;
	logic [3:0]    o_walk_state;
	logic [IW-1:0] o_hdr_index, o_exec_index;
	logic [2:0]    o_exec_area, want_area;
	logic [15:0]   o_pio_addr;
	logic [1:0]    o_pio_bank;
	logic [15:0]   pio_q[$];
	logic [11:0]   regs[5] = '{12'h0334, 12'h0338, 12'h033C, 12'h0350, 12'h0340};
	int            n_fail, check_count, cyc, good, bad, done_cyc, irq_cyc;

	hsp_sched_regs #(.NDESC(NDESC), .MS_CYCLES(8)) DUT (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_hdr_valid(hdr_valid),
		.i_hdr_skip(hdr_skip), .o_walk_state(o_walk_state), .o_hdr_index(o_hdr_index),
		.o_exec(o_exec), .o_exec_area(o_exec_area), .o_exec_index(o_exec_index),
		.i_async_done(async_done), .o_async_done_irq(o_irq), .i_pio_rd(i_pio_rd),
		.o_pio_go(o_pio_go), .o_pio_addr(o_pio_addr), .o_pio_bank(o_pio_bank));

	hsp_engine_model #(.NDESC(NDESC)) engine (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_walk_state(o_walk_state),
		.i_hdr_index(o_hdr_index), .i_exec(o_exec), .i_exec_area(o_exec_area),
		.o_hdr_valid(hdr_valid), .o_hdr_skip(hdr_skip), .o_async_done(async_done));

	// Clock of 10 ns.
	always #5 i_sys_clk = ~i_sys_clk;

	// Monitor: sorts executions, logs reads and event times, and cuts a hang short.
	always @(posedge i_sys_clk) begin
		cyc++;
		if (o_exec === 1'b1) begin
			if (o_exec_area === want_area && o_exec_index === IW'(1))
				good++;
			else
				bad++;
		end
		if (o_pio_go === 1'b1)
			pio_q.push_back(o_pio_addr);
		if (async_done === 1'b1 && done_cyc < 0)
			done_cyc = cyc;
		if (o_irq === 1'b1 && irq_cyc < 0)
			irq_cyc = cyc;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are looked at there.
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge i_sys_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd   <= 1'b0;
		#1 check($sformatf("rdata_%h", a), o_rdata, exp);
	endtask

	task automatic pio(input int n);
		pio_q.delete();
		@(posedge i_sys_clk);
		i_pio_rd <= 1'b1;
		repeat (n) @(posedge i_sys_clk);
		i_pio_rd <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
	endtask

	task automatic do_reset();
		i_reset <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		i_reset <= 1'b0;
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		i_sys_clk = 1'b0;
		{i_wr, i_rd, i_pio_rd, i_addr, i_wdata} = '0;
		{n_fail, check_count, cyc, good, bad} = '0;
		done_cyc  = -1;
		irq_cyc   = -1;
		want_area = '0;
		do_reset();
		// Reset values, an unmapped read and a full-width read-back.
		check("walk", 32'(o_walk_state), 32'h0000_0001);
		foreach (regs[i])
			rd(regs[i], 32'h0000_0000);
		wr(`HSP_OFF_TMO, 32'hA5A5_5A5A);
		rd(`HSP_OFF_TMO, 32'hA5A5_5A5A);
		wr(`HSP_OFF_TMO, 32'h0000_0000);
		$display("test reset_values done");

		// Each pending bit walks its own area and only the live header runs.
		for (int b = 2; b >= 0; b--) begin
			want_area = 3'(1 << b);
			good      = 0;
			bad       = 0;
			wr(`HSP_OFF_PEND, 32'(1 << b));
			repeat (24) @(posedge i_sys_clk);
			check("exec_seen", 32'(good > 0), 32'h0000_0001);
			check("exec_bad", 32'(bad), 32'h0000_0000);
			wr(`HSP_OFF_PEND, 32'h0000_0000);
			repeat (4) @(posedge i_sys_clk);
			good = 0;
			bad  = 0;
			repeat (24) @(posedge i_sys_clk);
			check("exec_idle", 32'(good + bad), 32'h0000_0000);
			check("walk_idle", 32'(o_walk_state), 32'h0000_0001);
		end
		// Completions happened with the interrupt disabled, so the line stays low.
		check("irq_off", 32'(o_irq), 32'h0000_0000);
		$display("test areas done");

		// Second reset, then the time-out with the interrupt enabled.
		do_reset();
		wr(`HSP_OFF_CTL, 32'h0000_0001);
		wr(`HSP_OFF_PEND, 32'h0000_0006);
		repeat (40) @(posedge i_sys_clk);
		check("irq_iso_int", 32'(o_irq), 32'h0000_0000);
		wr(`HSP_OFF_PEND, 32'h0000_0000);
		repeat (4) @(posedge i_sys_clk);
		wr(`HSP_OFF_TMO, 32'h0000_0002);
		done_cyc = -1;
		irq_cyc  = -1;
		wr(`HSP_OFF_PEND, 32'h0000_0001);
		for (int k = 0; k < 200 && irq_cyc < 0; k++)
			@(posedge i_sys_clk);
		// Two milliseconds of eight clocks each, plus arming and register stages.
		check("irq_delay", 32'(irq_cyc - done_cyc >= 16 && irq_cyc - done_cyc <= 21), 32'h0000_0001);
		wr(`HSP_OFF_PEND, 32'h0000_0000);
		wr(`HSP_OFF_CTL, 32'h0000_0003);
		@(posedge i_sys_clk);
		#1 check("irq_clear", 32'(o_irq), 32'h0000_0000);
		$display("test timeout done");

		// Programmed reads step the selected bank's pointer, wrapping at 16 bits.
		wr(`HSP_OFF_PTR, 32'h0002_0010);
		rd(`HSP_OFF_PTR, 32'h0002_0010);
		check("bank", 32'(o_pio_bank), 32'h0000_0002);
		pio(3);
		check("pio_n", 32'(pio_q.size()), 32'h0000_0003);
		foreach (pio_q[i])
			check("pio_addr", 32'(pio_q[i]), 32'(16'h0010 + i));
		rd(`HSP_OFF_PTR, 32'h0002_0013);
		wr(`HSP_OFF_PTR, 32'h0001_FFFF);
		#1 check("bank", 32'(o_pio_bank), 32'h0000_0001);
		pio(2);
		check("pio_wrap0", 32'(pio_q[0]), 32'h0000_FFFF);
		check("pio_wrap1", 32'(pio_q[1]), 32'h0000_0000);
		rd(`HSP_OFF_PTR, 32'h0001_0001);
		$display("test pio done");
		end_sim();
	end
endmodule
